// File: hdl/dmc_ctrl.sv
// Display memory addressing, scan line generation, reset and operating state control.
// Notes on behaviour
// [R1] A 65 by 192 display memory is written by the host and read by the scan.
// [R2] Data writes store at the current page and column pointers.
// [R3] Without wrap the column pointer stops at 191.
// [R4] With wrap the column returns to 0 and the page steps by the direction bit.
// [R5] Page stepping past page 0 or 7 continues at the other end.
// [R6] Column mirror writes to 191 minus column; stored data stays untouched.
// [R7] Scan order is fixed; settings only choose the memory line per period.
// [R8] Without row mirror first line is start line, then plus one modulo 64.
// [R9] With row mirror first line is start plus mux minus one, then minus one.
// [R10] Power-on reset holds system reset for about 5 ms, then releases it.
// [R11] Low reset pin triggers the same system reset as power-on.
// [R12] Any reset clears column and page and sets address control to 001b.
// [R13] Hardware reset alone restores temperature, power, scroll, bias and display bits.
// [R14] Hardware reset alone restores com end, bias ratio, mapping, frame, test, nv.
// [R15] Operating state reads 00 Reset, 10 Sleep, 11 Normal; pump and clock only in Normal.
// [R16] Writing the display enable bit moves the state to Sleep or Normal.
// [R17] State changes take effect on internal clock ticks.
// [R18] Host waits 10 us after display enable or reset before relying on state.
// [R19] Reset mode restores defaults; Sleep keeps user settings.
// [R20] Reset and Sleep disable drivers and enable draining.
// [R21] Drivers stay idle until the voltage ready indications are present.
// [R22] Host holds reset pin low 3 us, then waits 5 ms before commands.
`timescale 1ns/1ps
module dmc_ctrl #(
  parameter int POR_WAIT = dmc_pkg::POR_CYCLES,
  parameter int LINE_WAIT = dmc_pkg::LINE_CYCLES,
  parameter int OSC_DIVIDE = dmc_pkg::OSC_DIV
) (
  // Clock and power reset.
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // APB slave.
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Pins from outside.
  input wire logic I_RESET_PIN_N,
  input wire logic I_VLCD_READY,
  input wire logic I_VD_READY,
  // Scan side memory port.
  input wire logic [7:0] I_SCAN_COL,
  output logic O_SCAN_PIXEL,
  output logic [5:0] O_SCAN_LINE,
  output logic O_FRAME_START,
  // Power management outputs.
  output logic [1:0] O_OPERATING_STATE,
  output logic O_DRIVERS_EN,
  output logic O_DRAIN_EN,
  output logic O_PUMP_EN,
  output logic O_INT_CLK_EN
);

  if (POR_WAIT < 1 || LINE_WAIT < 1 || OSC_DIVIDE < 2 || OSC_DIVIDE > 256) begin : g_bad_params
    $error("dmc_ctrl: counts must be positive and the divider between 2 and 256");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and reset generation.

  logic [1:0] rstpin_sync_reg;
  logic [1:0] vlcd_sync_reg;
  logic [1:0] vd_sync_reg;
  logic [31:0] por_cnt_reg;
  logic por_busy_reg;
  logic hw_rst;

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rstpin_sync_reg <= 2'h0;
      vlcd_sync_reg <= 2'h0;
      vd_sync_reg <= 2'h0;
    end else begin
      rstpin_sync_reg <= {rstpin_sync_reg[0], I_RESET_PIN_N};
      vlcd_sync_reg <= {vlcd_sync_reg[0], I_VLCD_READY};
      vd_sync_reg <= {vd_sync_reg[0], I_VD_READY};
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      por_cnt_reg <= 32'h0;
      por_busy_reg <= 1'b1;
    end else if (por_busy_reg) begin
      if (por_cnt_reg == 32'(POR_WAIT - 1)) begin
        por_busy_reg <= 1'b0; // [R10]
      end
      por_cnt_reg <= por_cnt_reg + 32'h1;
    end
  end

  // Pin reset is taken as the same system reset as power-on.
  assign hw_rst = por_busy_reg | ~rstpin_sync_reg[1]; // [R10] [R11]

  //////////////////////////////////////////////////////////////////////////////
  // APB decode.

  logic wr_en;
  logic rd_en;
  logic soft_rst;
  logic mapped;

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      dmc_pkg::OFS_ADDR, dmc_pkg::OFS_ADDR_CTRL, dmc_pkg::OFS_DATA, dmc_pkg::OFS_DISP_CTRL,
      dmc_pkg::OFS_LCD_CTRL, dmc_pkg::OFS_SCROLL, dmc_pkg::OFS_BIAS, dmc_pkg::OFS_COM_END,
      dmc_pkg::OFS_POWER, dmc_pkg::OFS_COMMAND, dmc_pkg::OFS_STATUS,
      dmc_pkg::OFS_TEST_NV: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  assign mapped = is_mapped(I_PADDR);
  assign wr_en = I_PSEL & I_PENABLE & I_PWRITE & mapped;
  assign rd_en = I_PSEL & ~I_PENABLE & ~I_PWRITE;
  assign soft_rst = wr_en && I_PADDR == dmc_pkg::OFS_COMMAND && I_PWDATA[dmc_pkg::SOFT_RESET_BIT];
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = wr_en && I_PADDR == ofs;
  endfunction : wr_at

  //////////////////////////////////////////////////////////////////////////////
  // Control registers restored only by hardware reset.

  logic [1:0] temp_comp_reg;
  logic [2:0] power_control_reg;
  logic [5:0] scroll_start_line_reg;
  logic [7:0] bias_potentiometer_reg;
  logic [5:1] lcd_control_bits_reg;
  logic [2:0] display_control_bits_reg;
  logic [1:0] bias_ratio_reg;
  logic [6:0] last_com_index_reg;
  logic [7:0] test_ctrl_reg;
  logic [7:0] nv_ctrl_reg;

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      temp_comp_reg <= dmc_pkg::RST_TEMP_COMP;
      power_control_reg <= dmc_pkg::RST_PWR_CTRL;
      scroll_start_line_reg <= dmc_pkg::RST_SCROLL;
      bias_potentiometer_reg <= dmc_pkg::RST_BIAS_POT;
      lcd_control_bits_reg <= dmc_pkg::RST_LCD_CTRL;
      display_control_bits_reg <= dmc_pkg::RST_DISP_CTRL;
      bias_ratio_reg <= dmc_pkg::RST_BIAS_RATIO;
      last_com_index_reg <= dmc_pkg::RST_COM_END;
      test_ctrl_reg <= dmc_pkg::RST_TEST;
      nv_ctrl_reg <= dmc_pkg::RST_NV;
    end else if (hw_rst) begin
      temp_comp_reg <= dmc_pkg::RST_TEMP_COMP; // [R13] [R19]
      power_control_reg <= dmc_pkg::RST_PWR_CTRL; // [R13]
      scroll_start_line_reg <= dmc_pkg::RST_SCROLL; // [R13]
      bias_potentiometer_reg <= dmc_pkg::RST_BIAS_POT; // [R13]
      lcd_control_bits_reg <= dmc_pkg::RST_LCD_CTRL; // [R13] [R14]
      display_control_bits_reg <= dmc_pkg::RST_DISP_CTRL; // [R13]
      bias_ratio_reg <= dmc_pkg::RST_BIAS_RATIO; // [R14]
      last_com_index_reg <= dmc_pkg::RST_COM_END; // [R14]
      test_ctrl_reg <= dmc_pkg::RST_TEST; // [R14]
      nv_ctrl_reg <= dmc_pkg::RST_NV; // [R14]
    end else begin
      if (wr_at(dmc_pkg::OFS_POWER)) begin
        temp_comp_reg <= I_PWDATA[1:0];
        power_control_reg <= I_PWDATA[dmc_pkg::PWR_CTRL_LSB +: 3];
      end
      if (wr_at(dmc_pkg::OFS_SCROLL)) begin
        scroll_start_line_reg <= I_PWDATA[5:0];
      end
      if (wr_at(dmc_pkg::OFS_BIAS)) begin
        bias_potentiometer_reg <= I_PWDATA[7:0];
        bias_ratio_reg <= I_PWDATA[dmc_pkg::BIAS_RATIO_LSB +: 2];
      end
      if (wr_at(dmc_pkg::OFS_LCD_CTRL)) begin
        lcd_control_bits_reg <= I_PWDATA[5:1];
      end
      if (wr_at(dmc_pkg::OFS_DISP_CTRL)) begin
        display_control_bits_reg <= I_PWDATA[2:0];
      end
      if (wr_at(dmc_pkg::OFS_COM_END)) begin
        last_com_index_reg <= I_PWDATA[6:0];
      end
      if (wr_at(dmc_pkg::OFS_TEST_NV)) begin
        test_ctrl_reg <= I_PWDATA[7:0];
        nv_ctrl_reg <= I_PWDATA[dmc_pkg::NV_LSB +: 8];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Host addressing and display memory.

  logic [7:0] column_pointer_reg;
  logic [3:0] page_pointer_reg;
  logic [2:0] ram_addr_control_reg;
  logic [7:0] display_memory [dmc_pkg::NUM_PAGES * dmc_pkg::NUM_COLS];
  logic wrap_around_enable;
  logic row_step_direction;
  logic column_mirror;
  logic row_mirror;
  logic data_wr;
  logic [7:0] phys_col;
  logic [10:0] wr_index;

  assign wrap_around_enable = ram_addr_control_reg[dmc_pkg::WRAP_BIT];
  assign row_step_direction = ram_addr_control_reg[dmc_pkg::DIR_BIT];
  assign column_mirror = lcd_control_bits_reg[dmc_pkg::COL_MIRROR_BIT];
  assign row_mirror = lcd_control_bits_reg[dmc_pkg::ROW_MIRROR_BIT];
  assign data_wr = wr_at(dmc_pkg::OFS_DATA) & ~hw_rst;
  assign phys_col = column_mirror ? dmc_pkg::LAST_COL - column_pointer_reg
                                  : column_pointer_reg; // [R6]
  assign wr_index = 11'(page_pointer_reg * dmc_pkg::NUM_COLS) + 11'(phys_col);

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      column_pointer_reg <= dmc_pkg::RST_COL;
      page_pointer_reg <= dmc_pkg::RST_PAGE;
      ram_addr_control_reg <= dmc_pkg::RST_ADDR_CTRL;
    end else if (hw_rst || soft_rst) begin
      column_pointer_reg <= dmc_pkg::RST_COL; // [R12]
      page_pointer_reg <= dmc_pkg::RST_PAGE; // [R12]
      ram_addr_control_reg <= dmc_pkg::RST_ADDR_CTRL; // [R12]
    end else if (wr_at(dmc_pkg::OFS_ADDR)) begin
      column_pointer_reg <= I_PWDATA[7:0];
      page_pointer_reg <= I_PWDATA[dmc_pkg::PAGE_LSB +: 4];
    end else if (wr_at(dmc_pkg::OFS_ADDR_CTRL)) begin
      ram_addr_control_reg <= I_PWDATA[2:0];
    end else if (data_wr) begin
      if (column_pointer_reg < dmc_pkg::LAST_COL) begin
        column_pointer_reg <= column_pointer_reg + 8'h1;
      end else if (wrap_around_enable) begin
        column_pointer_reg <= 8'h0; // [R4]
        if (!row_step_direction) begin
          page_pointer_reg <= (page_pointer_reg >= dmc_pkg::LAST_WRAP_PAGE) ? 4'h0
                              : page_pointer_reg + 4'h1; // [R4] [R5]
        end else begin
          page_pointer_reg <= (page_pointer_reg == 4'h0) ? dmc_pkg::LAST_WRAP_PAGE
                              : page_pointer_reg - 4'h1; // [R4] [R5]
        end
      end
      // Without wrap the pointer parks on the last column until reloaded. [R3]
    end
  end

  // Writes outside the 65 by 192 map are dropped rather than aliased.
  always_ff @(posedge I_CLK_SYS) begin
    if (data_wr && page_pointer_reg < 4'(dmc_pkg::NUM_PAGES) &&
        phys_col <= dmc_pkg::LAST_COL) begin
      display_memory[wr_index] <= I_PWDATA[7:0]; // [R1] [R2]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Internal clock tick and operating state.

  logic [7:0] osc_cnt_reg;
  logic osc_tick;
  dmc_pkg::dmc_mode_type mode_reg;
  dmc_pkg::dmc_mode_type mode_target_reg;

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      osc_cnt_reg <= 8'h0;
    end else if (osc_cnt_reg == 8'(OSC_DIVIDE - 1)) begin
      osc_cnt_reg <= 8'h0;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 8'h1;
    end
  end

  assign osc_tick = osc_cnt_reg == 8'(OSC_DIVIDE - 1);

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      mode_target_reg <= dmc_pkg::ST_RESET;
    end else if (hw_rst || soft_rst) begin
      mode_target_reg <= dmc_pkg::ST_RESET;
    end else if (wr_at(dmc_pkg::OFS_DISP_CTRL)) begin
      mode_target_reg <= I_PWDATA[dmc_pkg::DISP_EN_BIT] ? dmc_pkg::ST_NORMAL
                                                       : dmc_pkg::ST_SLEEP; // [R16]
    end
  end

  // The state only follows its target on an internal clock tick, so a host
  // must allow the settling time before it trusts the reported state. [R18]
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      mode_reg <= dmc_pkg::ST_RESET;
    end else if (osc_tick) begin
      mode_reg <= mode_target_reg; // [R17]
    end
  end

  function automatic logic [1:0] mode_code(input dmc_pkg::dmc_mode_type m);
    case (m)
      dmc_pkg::ST_RESET: mode_code = dmc_pkg::OM_RESET;
      dmc_pkg::ST_SLEEP: mode_code = dmc_pkg::OM_SLEEP;
      dmc_pkg::ST_NORMAL: mode_code = dmc_pkg::OM_NORMAL;
      default: mode_code = dmc_pkg::OM_RESET;
    endcase
  endfunction : mode_code

  logic normal;
  assign normal = mode_reg == dmc_pkg::ST_NORMAL;

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_OPERATING_STATE <= dmc_pkg::OM_RESET;
      O_DRIVERS_EN <= 1'b0;
      O_DRAIN_EN <= 1'b1;
      O_PUMP_EN <= 1'b0;
      O_INT_CLK_EN <= 1'b0;
    end else begin
      O_OPERATING_STATE <= mode_code(mode_reg); // [R15]
      O_DRIVERS_EN <= normal & vlcd_sync_reg[1] & vd_sync_reg[1]; // [R20] [R21]
      O_DRAIN_EN <= ~normal; // [R20]
      O_PUMP_EN <= normal; // [R15]
      O_INT_CLK_EN <= normal; // [R15]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Scan line address generation; the electrode order itself never changes.

  logic [31:0] line_cnt_reg;
  logic [6:0] com_idx_reg;
  logic line_tick;
  logic [5:0] first_line;

  assign line_tick = normal && line_cnt_reg == 32'(LINE_WAIT - 1);
  assign first_line = row_mirror ? scroll_start_line_reg + last_com_index_reg[5:0]
                                 : scroll_start_line_reg; // [R8] [R9]

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      line_cnt_reg <= 32'h0;
    end else if (!normal || line_tick) begin
      line_cnt_reg <= 32'h0;
    end else begin
      line_cnt_reg <= line_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      com_idx_reg <= 7'h0;
      O_SCAN_LINE <= 6'h0;
      O_FRAME_START <= 1'b0;
    end else if (!normal) begin
      com_idx_reg <= 7'h0;
      O_SCAN_LINE <= first_line;
      O_FRAME_START <= 1'b0;
    end else if (line_tick) begin
      if (com_idx_reg >= last_com_index_reg) begin
        com_idx_reg <= 7'h0; // [R7]
        O_SCAN_LINE <= first_line; // [R8] [R9]
        O_FRAME_START <= 1'b1;
      end else begin
        com_idx_reg <= com_idx_reg + 7'h1; // [R7]
        O_SCAN_LINE <= row_mirror ? O_SCAN_LINE - 6'h1 : O_SCAN_LINE + 6'h1; // [R8] [R9]
        O_FRAME_START <= 1'b0;
      end
    end else begin
      O_FRAME_START <= 1'b0;
    end
  end

  // The scan port reads one pixel of the current line in the column asked for.
  logic [10:0] scan_index;
  assign scan_index = 11'(O_SCAN_LINE[5:3] * dmc_pkg::NUM_COLS) + 11'(I_SCAN_COL);

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SCAN_COL <= dmc_pkg::LAST_COL) begin
      O_SCAN_PIXEL <= display_memory[scan_index][O_SCAN_LINE[2:0]]; // [R1]
    end else begin
      O_SCAN_PIXEL <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data.

  // Taken in the setup cycle, the word comes from a flop and stands in the access cycle.
  logic [31:0] rd_word;
  always_ff @(posedge I_CLK_SYS) O_PRDATA <= rd_word;

  always_comb begin
    rd_word = 32'h0;
    if (rd_en) begin
      case (I_PADDR)
        dmc_pkg::OFS_ADDR: rd_word = {20'h0, page_pointer_reg, column_pointer_reg};
        dmc_pkg::OFS_ADDR_CTRL: rd_word = {29'h0, ram_addr_control_reg};
        dmc_pkg::OFS_DATA: begin
          if (page_pointer_reg < 4'(dmc_pkg::NUM_PAGES)) begin
            rd_word = {24'h0, display_memory[wr_index]};
          end
        end
        dmc_pkg::OFS_DISP_CTRL: rd_word = {29'h0, display_control_bits_reg};
        dmc_pkg::OFS_LCD_CTRL: rd_word = {26'h0, lcd_control_bits_reg, 1'b0};
        dmc_pkg::OFS_SCROLL: rd_word = {26'h0, scroll_start_line_reg};
        dmc_pkg::OFS_BIAS: rd_word = {22'h0, bias_ratio_reg, bias_potentiometer_reg};
        dmc_pkg::OFS_COM_END: rd_word = {25'h0, last_com_index_reg};
        dmc_pkg::OFS_POWER: rd_word = {27'h0, power_control_reg, temp_comp_reg};
        dmc_pkg::OFS_STATUS: rd_word = {18'h0, O_SCAN_LINE, 4'h0, O_DRAIN_EN, O_DRIVERS_EN,
                                        O_OPERATING_STATE};
        dmc_pkg::OFS_TEST_NV: rd_word = {16'h0, nv_ctrl_reg, test_ctrl_reg};
        default: rd_word = 32'h0;
      endcase
    end
  end

endmodule : dmc_ctrl

// File: hdl/dmc_pkg.sv
// Package with register map, reset values and timing constants of the display control block.
package dmc_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_ADDR_CTRL = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_DISP_CTRL = 8'h0c;
  localparam logic [7:0] OFS_LCD_CTRL = 8'h10;
  localparam logic [7:0] OFS_SCROLL = 8'h14;
  localparam logic [7:0] OFS_BIAS = 8'h18;
  localparam logic [7:0] OFS_COM_END = 8'h1c;
  localparam logic [7:0] OFS_POWER = 8'h20;
  localparam logic [7:0] OFS_COMMAND = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_TEST_NV = 8'h2c;

  // Field positions.
  localparam int PAGE_LSB = 8;
  localparam int WRAP_BIT = 0;
  localparam int DIR_BIT = 2;
  localparam int DISP_EN_BIT = 2;
  localparam int COL_MIRROR_BIT = 1;
  localparam int ROW_MIRROR_BIT = 2;
  localparam int BIAS_RATIO_LSB = 8;
  localparam int PWR_CTRL_LSB = 2;
  localparam int SOFT_RESET_BIT = 0;
  localparam int NV_LSB = 8;
  localparam int SCAN_LINE_LSB = 8;

  // Memory geometry.
  localparam int NUM_COLS = 192;
  localparam int NUM_PAGES = 9;
  localparam logic [7:0] LAST_COL = 8'hbf;
  localparam logic [3:0] LAST_WRAP_PAGE = 4'h7;

  // Values after reset.
  localparam logic [7:0] RST_COL = 8'h00;
  localparam logic [3:0] RST_PAGE = 4'h0;
  localparam logic [2:0] RST_ADDR_CTRL = 3'h1;
  localparam logic [1:0] RST_TEMP_COMP = 2'h0;
  localparam logic [2:0] RST_PWR_CTRL = 3'h6;
  localparam logic [5:0] RST_SCROLL = 6'h00;
  localparam logic [7:0] RST_BIAS_POT = 8'h49;
  localparam logic [5:1] RST_LCD_CTRL = 5'h00;
  localparam logic [2:0] RST_DISP_CTRL = 3'h0;
  localparam logic [1:0] RST_BIAS_RATIO = 2'h3;
  localparam logic [6:0] RST_COM_END = 7'h3f;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_NV = 8'h00;

  // Timing, times in their own unit and counts derived at 125 MHz.
  localparam int CLK_PERIOD_PS = 8000;
  localparam int POR_WAIT_US = 5000;
  localparam int POR_CYCLES = POR_WAIT_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int LINE_TIME_US = 91;
  localparam int LINE_CYCLES = LINE_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int OSC_DIV = 8;

  // Operating state encodings.
  localparam logic [1:0] OM_RESET = 2'h0;
  localparam logic [1:0] OM_SLEEP = 2'h2;
  localparam logic [1:0] OM_NORMAL = 2'h3;

  typedef enum logic [1:0] {ST_RESET, ST_SLEEP, ST_NORMAL} dmc_mode_type;

endpackage : dmc_pkg

// File: verif/dmc_ctrl_chk.sv
// Checker of power state outputs and scan line behaviour of the display control block.
`timescale 1ns/1ps
module dmc_ctrl_chk (
  // Clock and reset.
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // Pins and scan column.
  input wire logic I_RESET_PIN_N,
  input wire logic I_VLCD_READY,
  input wire logic I_VD_READY,
  input wire logic [7:0] I_SCAN_COL,
  // Watched outputs.
  input wire logic O_SCAN_PIXEL,
  input wire logic [5:0] O_SCAN_LINE,
  input wire logic O_FRAME_START,
  input wire logic [1:0] O_OPERATING_STATE,
  input wire logic O_DRIVERS_EN,
  input wire logic O_DRAIN_EN,
  input wire logic O_PUMP_EN,
  input wire logic O_INT_CLK_EN
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  ////////////////////////////////////////////////////////////////////////////////
  property p_state_code; O_OPERATING_STATE != 2'h1; endproperty
  a_state_code: assert property (p_state_code) else $error("undefined state code");
  property p_off;
    O_OPERATING_STATE != 2'h3 |-> !O_DRIVERS_EN && O_DRAIN_EN && !O_PUMP_EN && !O_INT_CLK_EN;
  endproperty
  a_off: assert property (p_off) else $error("outputs wrong outside normal");
  property p_on; O_OPERATING_STATE == 2'h3 |-> !O_DRAIN_EN && O_PUMP_EN && O_INT_CLK_EN; endproperty
  a_on: assert property (p_on) else $error("outputs wrong in normal");
  property p_drv; O_DRIVERS_EN |-> $past(I_VLCD_READY, 3) && $past(I_VD_READY, 3); endproperty
  a_drv: assert property (p_drv) else $error("drivers on before sources ready");
  // Mode steps come from the divided clock, so two of them never stand closer.
  property p_gap;
    $changed(O_OPERATING_STATE) && I_RESET_PIN_N |=> $stable(O_OPERATING_STATE) [*6];
  endproperty
  a_gap: assert property (p_gap) else $error("state changed off the slow clock");
  property p_frame; O_FRAME_START |=> !O_FRAME_START; endproperty
  a_frame: assert property (p_frame) else $error("frame start longer than one cycle");
  property p_step;
    O_OPERATING_STATE == 2'h3 && $changed(O_SCAN_LINE) && !O_FRAME_START
      |-> O_SCAN_LINE == $past(O_SCAN_LINE) + 6'h1 || O_SCAN_LINE == $past(O_SCAN_LINE) - 6'h1;
  endproperty
  a_step: assert property (p_step) else $error("scan line jumped");
  property p_oob; $past(I_SCAN_COL) > 8'hbf |-> !O_SCAN_PIXEL; endproperty
  a_oob: assert property (p_oob) else $error("pixel beyond last column");
endmodule : dmc_ctrl_chk

bind dmc_ctrl dmc_ctrl_chk i_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST),
  .I_RESET_PIN_N(I_RESET_PIN_N), .I_VLCD_READY(I_VLCD_READY), .I_VD_READY(I_VD_READY),
  .I_SCAN_COL(I_SCAN_COL), .O_SCAN_PIXEL(O_SCAN_PIXEL), .O_SCAN_LINE(O_SCAN_LINE),
  .O_FRAME_START(O_FRAME_START), .O_OPERATING_STATE(O_OPERATING_STATE),
  .O_DRIVERS_EN(O_DRIVERS_EN), .O_DRAIN_EN(O_DRAIN_EN), .O_PUMP_EN(O_PUMP_EN),
  .O_INT_CLK_EN(O_INT_CLK_EN));

// File: verif/dmc_ctrl_tb_top.sv
// Testbench of the display control block.
`timescale 1ns/1ps
module dmc_ctrl_tb_top;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, pin_n, vlcd, vd, pixel, fstart;
  logic drv, drain, pump, clken, err;
  logic [7:0] paddr, scol;
  logic [31:0] pwdata, prdata, r;
  logic [5:0] line;
  logic [1:0] state;
  int num_errors = 0;
  int samples_checked = 0;
  dmc_ctrl #(.POR_WAIT(20), .LINE_WAIT(4), .OSC_DIVIDE(8)) i_dut (.I_CLK_SYS(clk), .I_RST(rst),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RESET_PIN_N(pin_n),
    .I_VLCD_READY(vlcd), .I_VD_READY(vd), .I_SCAN_COL(scol), .O_SCAN_PIXEL(pixel),
    .O_SCAN_LINE(line), .O_FRAME_START(fstart), .O_OPERATING_STATE(state), .O_DRIVERS_EN(drv),
    .O_DRAIN_EN(drain), .O_PUMP_EN(pump), .O_INT_CLK_EN(clken));
  dmc_supply_model i_model (.i_clk(clk), .i_rst(rst), .i_pump_en(pump), .o_vlcd_ready(vlcd),
    .o_vd_ready(vd), .o_scan_col(scol));
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic bad(input string m);
    $display("BAD %0t %s", $time, m);
    num_errors++;
    tally_and_finish();
  endtask : bad
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk32
  // One APB transfer; the request stands until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic e);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk); penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) bad("no pready");
      @(posedge clk);
    end
    rd = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, err);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, r, err);
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk32(r, exp);
  endtask : rdc
  task automatic wait_state(input logic [1:0] s);
    int n;
    for (n = 0; state !== s; n++) begin
      if (n > 100) bad("state not reached");
      @(posedge clk);
    end
  endtask : wait_state
  task automatic wait_frame();
    int n;
    @(posedge clk);
    for (n = 0; fstart !== 1'b1; n++) begin
      if (n > 300) bad("no frame start");
      @(posedge clk);
    end
  endtask : wait_frame
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    rdc(dmc_pkg::OFS_ADDR, 32'h0);
    rdc(dmc_pkg::OFS_ADDR_CTRL, 32'h1);
    rdc(dmc_pkg::OFS_POWER, 32'h18);
    rdc(dmc_pkg::OFS_BIAS, 32'h349);
    rdc(dmc_pkg::OFS_COM_END, 32'h3f);
    rdc(dmc_pkg::OFS_SCROLL, 32'h0);
    rdc(dmc_pkg::OFS_STATUS, 32'h8);
    apb(1'b0, 8'h30, 32'h0, r, err);
    chk32({31'h0, err}, 32'h1);
  endtask : t_reset_values
  task automatic t_addressing();
    wr(dmc_pkg::OFS_ADDR_CTRL, 32'h1);
    wr(dmc_pkg::OFS_ADDR, 32'h7be);
    wr(dmc_pkg::OFS_DATA, 32'ha5);
    wr(dmc_pkg::OFS_DATA, 32'h3c);
    wr(dmc_pkg::OFS_DATA, 32'hc3);
    rdc(dmc_pkg::OFS_ADDR, 32'h001);
    wr(dmc_pkg::OFS_ADDR, 32'h7bf);
    rdc(dmc_pkg::OFS_DATA, 32'h3c);
    wr(dmc_pkg::OFS_ADDR, 32'h0);
    rdc(dmc_pkg::OFS_DATA, 32'hc3);
    wr(dmc_pkg::OFS_ADDR_CTRL, 32'h5);
    wr(dmc_pkg::OFS_ADDR, 32'h0bf);
    wr(dmc_pkg::OFS_DATA, 32'h11);
    rdc(dmc_pkg::OFS_ADDR, 32'h700);
    wr(dmc_pkg::OFS_ADDR_CTRL, 32'h0);
    wr(dmc_pkg::OFS_ADDR, 32'h3bf);
    wr(dmc_pkg::OFS_DATA, 32'h22);
    rdc(dmc_pkg::OFS_ADDR, 32'h3bf);
  endtask : t_addressing
  task automatic t_mirror();
    wr(dmc_pkg::OFS_LCD_CTRL, 32'h2);
    wr(dmc_pkg::OFS_ADDR, 32'h205);
    wr(dmc_pkg::OFS_DATA, 32'h5a);
    wr(dmc_pkg::OFS_LCD_CTRL, 32'h0);
    wr(dmc_pkg::OFS_ADDR, 32'h2ba);
    rdc(dmc_pkg::OFS_DATA, 32'h5a);
    wr(dmc_pkg::OFS_ADDR, 32'h7bf);
    rdc(dmc_pkg::OFS_DATA, 32'h3c);
  endtask : t_mirror
  task automatic t_modes();
    wr(dmc_pkg::OFS_SCROLL, 32'h5);
    wr(dmc_pkg::OFS_DISP_CTRL, 32'h4);
    wait_state(2'h3);
    repeat (1250) @(posedge clk);
    rd(dmc_pkg::OFS_STATUS);
    chk32(r & 32'hf, 32'h7);
    wr(dmc_pkg::OFS_DISP_CTRL, 32'h0);
    wait_state(2'h2);
    repeat (1250) @(posedge clk);
    rd(dmc_pkg::OFS_STATUS);
    chk32(r & 32'hf, 32'ha);
    rdc(dmc_pkg::OFS_SCROLL, 32'h5);
    wr(dmc_pkg::OFS_COMMAND, 32'h1);
    wait_state(2'h0);
    rdc(dmc_pkg::OFS_ADDR, 32'h0);
    rdc(dmc_pkg::OFS_ADDR_CTRL, 32'h1);
    rdc(dmc_pkg::OFS_SCROLL, 32'h5);
  endtask : t_modes
  task automatic t_scan();
    wr(dmc_pkg::OFS_SCROLL, 32'h3e);
    wr(dmc_pkg::OFS_COM_END, 32'h3);
    wr(dmc_pkg::OFS_DISP_CTRL, 32'h4);
    wait_state(2'h3);
    wait_frame();
    chk32({26'h0, line}, 32'h3e);
    repeat (4) @(posedge clk);
    chk32({26'h0, line}, 32'h3f);
    wr(dmc_pkg::OFS_LCD_CTRL, 32'h4);
    wait_frame();
    wait_frame();
    chk32({26'h0, line}, 32'h1);
    repeat (4) @(posedge clk);
    chk32({26'h0, line}, 32'h0);
  endtask : t_scan
  task automatic t_pin_reset();
    wr(dmc_pkg::OFS_SCROLL, 32'h9);
    pin_n <= 1'b0;
    repeat (375) @(posedge clk);
    wait_state(2'h0);
    pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(dmc_pkg::OFS_SCROLL, 32'h0);
    rdc(dmc_pkg::OFS_LCD_CTRL, 32'h0);
  endtask : t_pin_reset
  initial begin
    clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; pin_n = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (40) @(posedge clk);
    t_reset_values();
    t_addressing();
    t_mirror();
    t_modes();
    t_scan();
    t_pin_reset();
    tally_and_finish();
  end
endmodule : dmc_ctrl_tb_top

// File: verif/dmc_supply_model.sv
// Model of the panel side: voltage source ready flags and a scan column sweep.
`timescale 1ns/1ps
module dmc_supply_model (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Pump control from the block.
  input wire logic i_pump_en,
  // Ready flags and scan column.
  output logic o_vlcd_ready,
  output logic o_vd_ready,
  output logic [7:0] o_scan_col
);
  logic [3:0] settle_reg;
  // Sources need time after the pump starts, and fall at once when it stops.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst || !i_pump_en) begin
      settle_reg <= 4'h0;
    end else if (settle_reg != 4'hf) begin
      settle_reg <= settle_reg + 4'h1;
    end
  end
  assign o_vd_ready = settle_reg >= 4'h3;
  assign o_vlcd_ready = settle_reg >= 4'h9;
  // The sweep runs past column 191 so the blank columns are read too.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst || o_scan_col == 8'hc7) begin
      o_scan_col <= 8'h00;
    end else begin
      o_scan_col <= o_scan_col + 8'h01;
    end
  end
endmodule : dmc_supply_model
